// ---- verilog/ebu_map.svh ----
// Purpose: Constant map of the external bus unit
// Assumes: Included by the package and the design modules
// Notes:   Widths, counts, positions, codes and reset values only
`ifndef EBU_MAP_SVH
`define EBU_MAP_SVH

`define EBU_ADDR_W       24
`define EBU_SPACE_W      26
`define EBU_DATA_W       16
`define EBU_NUM_CS       8
`define EBU_NUM_LOCS     4
`define EBU_NUM_HICS     4
`define EBU_HICS_LSB     20
`define EBU_REGION_LSB   20
`define EBU_REGION_W     6
`define EBU_IDX_W        3
`define EBU_CNT_W        3
`define EBU_BOOT_REGION  6'h00
`define EBU_BOOT_CS      3'h0
`define EBU_CNT_ZERO     3'h0
`define EBU_PIN_ADDR_RST 24'h00_0000
`define EBU_SPACE_RST    26'h000_0000
`define EBU_DATA_RST     16'h0000
`define EBU_BYTE_ZERO    8'h00
`define EBU_HICS_RST     4'h0
`define EBU_BE_BOTH      2'h3
`define EBU_BE_HIGH      2'h2

`endif

// ---- verilog/ebu_pkg.sv ----
// Purpose: Types shared by the external bus unit modules
// Assumes: ebu_map.svh supplies all widths except those of be and ebu_state_e
// Notes:   Region config is per chip select
`default_nettype none
`include "ebu_map.svh"

package ebu_pkg;

    typedef struct packed {
        logic                          enable;
        logic [`EBU_REGION_W-1:0]      base;
        logic [`EBU_REGION_W-1:0]      mask;
        logic                          width16;
        logic                          read_late;
        logic [`EBU_CNT_W-1:0]         wait_states;
        logic [`EBU_CNT_W-1:0]         float_cycles;
    } ebu_cs_cfg_s;

    typedef struct packed {
        logic                          write;
        logic [`EBU_SPACE_W-1:0]       addr;
        logic [`EBU_DATA_W-1:0]        wdata;
        logic [1:0]                    be;
    } ebu_req_s;

    typedef enum logic [1:0] {
        EBU_IDLE,
        EBU_SETUP,
        EBU_STROBE,
        EBU_HOLD
    } ebu_state_e;

endpackage : ebu_pkg
`default_nettype wire

// ---- verilog/ebu_cs_decode.sv ----
// Purpose: Region match and chip select selection
// Assumes: Lowest matching chip select wins
// Notes:   Boot region forced to chip select 0 until remap
`timescale 1ns/1ps
`default_nettype none
`include "ebu_map.svh"

module ebu_cs_decode (
    // Access
    input  wire logic [`EBU_REGION_W-1:0]                region,
    input  wire logic                                    boot_active,
    // Configuration
    input  wire ebu_pkg::ebu_cs_cfg_s [`EBU_NUM_CS-1:0]  cs_cfg,
    // Result
    output logic                                         hit,
    output logic [`EBU_IDX_W-1:0]                        idx
);
    import ebu_pkg::*;

    logic [`EBU_NUM_CS-1:0] match;
    wire                    boot_hit = boot_active && (region == `EBU_BOOT_REGION);

    // base and mask over the 64 MB space
    genvar gi;
    generate
        for (gi = 0; gi < `EBU_NUM_CS; gi++) begin : g_match
            assign match[gi] = cs_cfg[gi].enable &&
                               (((region ^ cs_cfg[gi].base) & cs_cfg[gi].mask) == '0);
        end
    endgenerate

    always_comb begin
        hit = boot_hit;
        idx = `EBU_BOOT_CS;
        if (!boot_hit) begin
            for (int i = `EBU_NUM_CS - 1; i >= 0; i--) begin
                if (match[i]) begin
                    hit = 1'b1;
                    idx = i[`EBU_IDX_W-1:0];
                end
            end
        end
    end

endmodule : ebu_cs_decode
`default_nettype wire

// ---- verilog/ebu_top.sv ----
// Purpose: External bus unit, internal requests to SRAM/flash pin cycles
// Assumes: One request at a time; pins synchronous to clk
// Notes:   Both strobe sets are driven; the unused set idles high
// How it works
// - Addresses leave on a 24-bit bus whose top four lines can become chip selects.
// - After reset the four shared lines carry address bits 23..20 until software switches them.
// - Every address pin holds a defined level from the release of reset.
// - Eight chip selects exist, four low-true dedicated and four high-true shared.
// - Region base and mask per chip select span a 64 MB space.
// - The 16-bit data bus serves each region as 8-bit or 16-bit.
// - A byte-write or a byte-select strobe set is chosen, all strobes low-true.
// - Read and write strobes are separate so devices need no decoding.
// - Programmed wait states stretch the strobe, and so does a low wait request.
// - A programmed float time passes before the next cycle may start.
// - Reads use either an early or a late read strobe protocol.
// - With no waits a read strobe lasts a single clock cycle.
// - The boot mode pin is caught during reset and boot memory is remapped on command.
`timescale 1ns/1ps
`default_nettype none
`include "ebu_map.svh"

module ebu_top (
    // Clock and reset
    input  wire logic                                    clk,
    input  wire logic                                    sys_rst,
    // Internal request
    input  wire logic                                    req_valid,
    input  wire ebu_pkg::ebu_req_s                       req,
    output logic                                         req_ready,
    output logic                                         rsp_valid,
    output logic                                         rsp_error,
    output logic [`EBU_DATA_W-1:0]                       rsp_rdata,
    // Configuration and status
    input  wire ebu_pkg::ebu_cs_cfg_s [`EBU_NUM_CS-1:0]  cs_cfg,
    input  wire logic [`EBU_NUM_HICS-1:0]                high_cs_enable,
    input  wire logic                                    byte_select_mode,
    input  wire logic                                    remap_set,
    output logic                                         remap_done,
    output logic                                         boot_width16,
    // External pins
    output logic [`EBU_ADDR_W-1:0]                       addr_pins,
    output logic [`EBU_NUM_LOCS-1:0]                     low_chip_selects_n,
    input  wire logic [`EBU_DATA_W-1:0]                  data_in,
    output logic [`EBU_DATA_W-1:0]                       data_out,
    output logic                                         data_oe,
    output logic                                         low_byte_write_strobe_n,
    output logic                                         upper_byte_write_strobe_n,
    output logic                                         read_strobe_n,
    output logic                                         write_enable_strobe_n,
    output logic                                         output_enable_strobe_n,
    output logic                                         upper_byte_select_n,
    output logic                                         lower_byte_select_n,
    input  wire logic                                    wait_request_n,
    input  wire logic                                    boot_mode_select_pin
);
    import ebu_pkg::*;

    ebu_state_e              state_reg, state_next;
    ebu_cs_cfg_s             cfg_reg, cfg_next;
    logic [`EBU_SPACE_W-1:0] addr_reg, addr_next;
    logic [`EBU_DATA_W-1:0]  wdata_reg, rdata_reg, rdata_next;
    logic [1:0]              be_reg, be_next;
    logic [`EBU_IDX_W-1:0]   idx_reg, idx_next;
    logic [`EBU_CNT_W-1:0]   cnt_reg, cnt_next;
    logic                    write_reg, write_next;
    logic                    beat_reg, beat_next;
    logic                    rsp_valid_reg, rsp_valid_next;
    logic                    rsp_error_reg, rsp_error_next;
    logic [`EBU_NUM_HICS-1:0] hics_reg;
    logic                    boot_mode_reg;
    logic                    remap_reg;
    logic                    hit;
    logic [`EBU_IDX_W-1:0]   hit_idx;

    ebu_cs_decode u_decode (
        .region      (req.addr[`EBU_SPACE_W-1:`EBU_REGION_LSB]),
        .boot_active (!remap_reg),
        .cs_cfg      (cs_cfg),
        .hit         (hit),
        .idx         (hit_idx)
    );

    // Boot access width follows the strap until remap
    wire boot_sel = !remap_reg && (hit_idx == `EBU_BOOT_CS);
    ebu_cs_cfg_s sel_cfg;
    always_comb begin
        sel_cfg = cs_cfg[hit_idx];
        if (boot_sel) begin
            sel_cfg.width16 = boot_mode_reg;
        end
    end

    wire accept     = req_valid && (state_reg == EBU_IDLE);
    wire in_strobe  = (state_reg == EBU_STROBE);
    wire cs_active  = (state_reg != EBU_IDLE);
    wire wait_done  = in_strobe && (cnt_reg == `EBU_CNT_ZERO) && wait_request_n;
    // halfword to 8-bit device splits in two beats
    wire two_beat   = !cfg_reg.width16 && (be_reg == `EBU_BE_BOTH);
    wire lane_hi    = cfg_reg.width16 ? 1'b0 : (beat_reg || (be_reg == `EBU_BE_HIGH));
    wire last_beat  = !two_beat || beat_reg;
    // late reads and writes get a setup cycle
    wire need_setup = req.write || sel_cfg.read_late;
    wire beat_setup = write_reg || cfg_reg.read_late;

    always_comb begin
        state_next     = state_reg;
        cfg_next       = cfg_reg;
        addr_next      = addr_reg;
        be_next        = be_reg;
        idx_next       = idx_reg;
        cnt_next       = cnt_reg;
        write_next     = write_reg;
        beat_next      = beat_reg;
        rdata_next     = rdata_reg;
        rsp_valid_next = 1'b0;
        rsp_error_next = 1'b0;
        case (state_reg)
            EBU_IDLE: begin
                if (accept && !hit) begin
                    rsp_valid_next = 1'b1;
                    rsp_error_next = 1'b1;
                end else if (accept) begin
                    cfg_next   = sel_cfg;
                    addr_next  = req.addr;
                    be_next    = req.be;
                    idx_next   = hit_idx;
                    write_next = req.write;
                    beat_next  = 1'b0;
                    rdata_next = `EBU_DATA_RST;
                    cnt_next   = sel_cfg.wait_states;
                    state_next = need_setup ? EBU_SETUP : EBU_STROBE;
                end
            end
            EBU_SETUP: begin
                cnt_next   = cfg_reg.wait_states;
                state_next = EBU_STROBE;
            end
            EBU_STROBE: begin
                if (cnt_reg != `EBU_CNT_ZERO) begin
                    cnt_next = cnt_reg - 1'b1;
                end else if (wait_request_n) begin
                    if (cfg_reg.width16) begin
                        rdata_next = data_in;
                    end else if (lane_hi) begin
                        rdata_next = {data_in[7:0], rdata_reg[7:0]};
                    end else begin
                        rdata_next = {rdata_reg[15:8], data_in[7:0]};
                    end
                    rsp_valid_next = last_beat;
                    cnt_next       = cfg_reg.float_cycles;
                    state_next     = EBU_HOLD;
                end
            end
            EBU_HOLD: begin
                // float time before any new cycle
                if (cnt_reg != `EBU_CNT_ZERO) begin
                    cnt_next = cnt_reg - 1'b1;
                end else if (!last_beat) begin
                    beat_next  = 1'b1;
                    cnt_next   = cfg_reg.wait_states;
                    state_next = beat_setup ? EBU_SETUP : EBU_STROBE;
                end else begin
                    state_next = EBU_IDLE;
                end
            end
            default: begin
                state_next = EBU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= EBU_IDLE;
            cnt_reg   <= `EBU_CNT_ZERO;
            beat_reg  <= 1'b0;
            write_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            beat_reg  <= beat_next;
            write_reg <= write_next;
        end
    end

    // address defined at reset, held per access
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            addr_reg <= `EBU_SPACE_RST;
            cfg_reg  <= '0;
            be_reg   <= '0;
            idx_reg  <= `EBU_BOOT_CS;
        end else begin
            addr_reg <= addr_next;
            cfg_reg  <= cfg_next;
            be_reg   <= be_next;
            idx_reg  <= idx_next;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wdata_reg     <= `EBU_DATA_RST;
            rdata_reg     <= `EBU_DATA_RST;
            rsp_valid_reg <= 1'b0;
            rsp_error_reg <= 1'b0;
        end else begin
            wdata_reg     <= accept ? req.wdata : wdata_reg;
            rdata_reg     <= rdata_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_error_reg <= rsp_error_next;
        end
    end

    // strap caught while reset held, remap sticky
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            boot_mode_reg <= boot_mode_select_pin;
            remap_reg     <= 1'b0;
        end else begin
            remap_reg     <= remap_reg || remap_set;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hics_reg <= `EBU_HICS_RST;
        end else begin
            hics_reg <= high_cs_enable;
        end
    end

    wire [`EBU_NUM_CS-1:0] cs_onehot = cs_active ? (`EBU_NUM_CS'(1) << idx_reg) : '0;
    assign low_chip_selects_n = ~cs_onehot[`EBU_NUM_LOCS-1:0];

    // address bus with shared top lines
    wire [`EBU_ADDR_W-1:0] pin_addr = {addr_reg[`EBU_ADDR_W-1:1],
                                       cfg_reg.width16 ? addr_reg[0] : lane_hi};
    genvar gh;
    generate
        for (gh = 0; gh < `EBU_NUM_HICS; gh++) begin : g_hics
            // High select n sits on address line 23 - n
            localparam int PIN = `EBU_ADDR_W - 1 - gh;
            assign addr_pins[PIN] = hics_reg[gh] ? cs_onehot[`EBU_NUM_LOCS + gh]
                                                 : pin_addr[PIN];
        end
    endgenerate
    assign addr_pins[`EBU_HICS_LSB-1:0] = pin_addr[`EBU_HICS_LSB-1:0];

    // strobe sets, unused set parked high
    wire rd_on  = in_strobe && !write_reg;
    wire wr_on  = in_strobe && write_reg;
    wire lane0  = cfg_reg.width16 ? be_reg[0] : 1'b1;
    wire lane1  = cfg_reg.width16 && be_reg[1];
    assign low_byte_write_strobe_n   = !(!byte_select_mode && wr_on && lane0);
    assign upper_byte_write_strobe_n = !(!byte_select_mode && wr_on && lane1);
    assign read_strobe_n             = !(!byte_select_mode && rd_on);
    assign write_enable_strobe_n     = !(byte_select_mode && wr_on);
    assign output_enable_strobe_n    = !(byte_select_mode && rd_on);
    assign upper_byte_select_n       = !(byte_select_mode && cs_active && lane1);
    assign lower_byte_select_n       = !(byte_select_mode && cs_active && lane0);

    // Byte data rides on the low lane for 8-bit devices
    assign data_out  = lane_hi ? {`EBU_BYTE_ZERO, wdata_reg[15:8]} : wdata_reg;
    assign data_oe   = write_reg && (state_reg == EBU_SETUP || in_strobe);
    assign req_ready = (state_reg == EBU_IDLE);
    assign rsp_valid = rsp_valid_reg;
    assign rsp_error = rsp_error_reg;
    assign rsp_rdata = rdata_reg;
    assign remap_done   = remap_reg;
    assign boot_width16 = boot_mode_reg;

    a_reset_addr: assert property (@(posedge clk)
        $past(sys_rst) |-> addr_pins == `EBU_PIN_ADDR_RST)
        else $error("address pins not defined after reset");
    a_shared_addr: assert property (@(posedge clk) disable iff (sys_rst)
        !hics_reg[0] |-> addr_pins[`EBU_ADDR_W-1] == addr_reg[`EBU_ADDR_W-1])
        else $error("shared line not carrying address");
    a_cs_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        $countones(~low_chip_selects_n) <= 1)
        else $error("more than one low chip select active");
    a_strobe_set: assert property (@(posedge clk) disable iff (sys_rst)
        !byte_select_mode |-> write_enable_strobe_n && output_enable_strobe_n)
        else $error("byte-select strobe active in byte-write mode");
    a_rd_wr_apart: assert property (@(posedge clk) disable iff (sys_rst)
        !(!read_strobe_n && !(low_byte_write_strobe_n && upper_byte_write_strobe_n)))
        else $error("read and write strobes together");
    a_wait_stretch: assert property (@(posedge clk) disable iff (sys_rst)
        in_strobe && !wait_request_n |=> in_strobe)
        else $error("strobe ended under wait request");
    a_float_gap: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(state_reg == EBU_HOLD) && cfg_reg.float_cycles == 3'h2 |-> !req_ready[*3])
        else $error("new cycle inside float time");
    a_single_read: assert property (@(posedge clk) disable iff (sys_rst)
        accept && hit && !req.write && !sel_cfg.read_late && sel_cfg.wait_states == 3'h0 &&
        (sel_cfg.width16 || req.be != `EBU_BE_BOTH) ##1 wait_request_n |->
        !read_strobe_n || !output_enable_strobe_n ##1 rsp_valid)
        else $error("zero-wait read not done in one strobe cycle");
    a_addr_stable: assert property (@(posedge clk) disable iff (sys_rst)
        in_strobe |=> $stable(addr_pins) && $stable(low_chip_selects_n))
        else $error("address moved at strobe end");

endmodule : ebu_top
`default_nettype wire

// ---- bench/ebu_mem_model.sv ----
// Purpose: Behavioural external memory hanging on the bus unit pins
// Assumes: Byte array, selected by any low-true chip select
// Notes:   Released data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module ebu_mem_model (
    // Clock
    input  wire logic        clk,
    // Pins from the unit
    input  wire logic [23:0] addr_pins,
    input  wire logic [3:0]  low_chip_selects_n,
    input  wire logic [15:0] data_out,
    input  wire logic [6:0]  strobes_n,
    output logic      [15:0] data_in,
    output logic             wait_request_n,
    // Test control
    input  wire logic        narrow,
    input  wire logic [2:0]  stall
);
    logic [7:0]  mem [0:255];
    logic [15:0] last_reg = 16'h0000;
    logic [2:0]  cnt_reg = 3'h0;
    logic        sel;
    logic        rd;
    logic        wr;
    logic [7:0]  a;
    logic [7:0]  al;
    logic [7:0]  ah;

    assign sel = low_chip_selects_n != 4'hF;
    assign rd  = sel && !(strobes_n[4] && strobes_n[2]);
    assign wr  = sel && !(strobes_n[6] && strobes_n[5] && strobes_n[3]);
    assign a   = addr_pins[7:0];
    assign al  = {a[7:1], 1'b0};
    assign ah  = {a[7:1], 1'b1};
    assign wait_request_n = !((rd || wr) && cnt_reg < stall);
    // Floating bus must not look like stale data
    assign data_in = !rd ? ~last_reg : narrow ? {8'h00, mem[a]} : {mem[ah], mem[al]};

    always @(posedge clk) begin
        last_reg <= data_in;
        cnt_reg  <= (rd || wr) ? cnt_reg + 3'h1 : 3'h0;
        if (wr && narrow) begin
            mem[a] <= data_out[7:0];
        end else if (wr) begin
            if (!(strobes_n[6] && (strobes_n[3] || strobes_n[0]))) begin
                mem[al] <= data_out[7:0];
            end
            if (!(strobes_n[5] && (strobes_n[3] || strobes_n[1]))) begin
                mem[ah] <= data_out[15:8];
            end
        end
    end
endmodule : ebu_mem_model

`default_nettype wire

// ---- bench/ebu_top_tb.sv ----
// Purpose: Self-checking bench for the external bus unit
// Assumes: Requests issued only when the unit is idle
// Notes:   Model memory aliases all regions on the low address byte
`timescale 1ns/1ps
`default_nettype none

`define EBU_CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module ebu_top_tb;
    import ebu_pkg::*;
    logic               clk;
    logic               sys_rst;
    logic               req_valid;
    ebu_req_s           req;
    logic               req_ready;
    logic               rsp_valid;
    logic               rsp_error;
    logic [15:0]        rsp_rdata;
    ebu_cs_cfg_s [7:0]  cs_cfg;
    logic [3:0]         high_cs_enable;
    logic               byte_select_mode;
    logic               remap_set;
    logic               remap_done;
    logic               boot_width16;
    logic [23:0]        addr_pins;
    logic [3:0]         low_chip_selects_n;
    logic [15:0]        data_in;
    logic [15:0]        data_out;
    logic               data_oe;
    logic               low_byte_write_strobe_n;
    logic               upper_byte_write_strobe_n;
    logic               read_strobe_n;
    logic               write_enable_strobe_n;
    logic               output_enable_strobe_n;
    logic               upper_byte_select_n;
    logic               lower_byte_select_n;
    logic               wait_request_n;
    logic               boot_mode_select_pin;
    logic               narrow;
    logic [2:0]         stall;
    logic [6:0]         stb_n;
    logic [15:0]        rdat;
    logic               rerr;
    logic [7:0]         seen;
    logic [3:0]         apin;
    int                 nstb;
    int                 ncs;
    int                 gap;
    int                 cyc;
    int                 bad_count;
    int                 check_count;

    assign stb_n = {low_byte_write_strobe_n, upper_byte_write_strobe_n, read_strobe_n,
                    write_enable_strobe_n, output_enable_strobe_n,
                    upper_byte_select_n, lower_byte_select_n};

    ebu_top DUT (.clk, .sys_rst, .req_valid, .req, .req_ready, .rsp_valid, .rsp_error,
        .rsp_rdata, .cs_cfg, .high_cs_enable, .byte_select_mode, .remap_set, .remap_done,
        .boot_width16, .addr_pins, .low_chip_selects_n, .data_in, .data_out, .data_oe,
        .low_byte_write_strobe_n, .upper_byte_write_strobe_n, .read_strobe_n,
        .write_enable_strobe_n, .output_enable_strobe_n, .upper_byte_select_n,
        .lower_byte_select_n, .wait_request_n, .boot_mode_select_pin);

    ebu_mem_model MEM (.clk, .addr_pins, .low_chip_selects_n, .data_out,
        .strobes_n(stb_n), .data_in, .wait_request_n, .narrow, .stall);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic ebu_cs_cfg_s mk(input logic [5:0] b, input logic w16,
                                       input logic late, input logic [2:0] ws,
                                       input logic [2:0] fl);
        return {1'b1, b, 6'h3F, w16, late, ws, fl};
    endfunction : mk

    task automatic test_done();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // One request, then per-cycle pin observation until idle again
    task automatic acc(input logic w, input logic [25:0] ad, input logic [15:0] wd,
                       input logic [1:0] be);
        logic done;
        done = 1'b0;
        nstb = 0;
        ncs = 0;
        gap = 0;
        seen = 8'h00;
        @(posedge clk);
        req_valid <= 1'b1;
        req       <= {w, ad, wd, be};
        #1;
        while (req_ready !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        req_valid <= 1'b0;
        for (int n = 0; n < 64; n++) begin
            #1;
            if (done && req_ready === 1'b1) break;
            if (stb_n[6:2] != 5'h1F) nstb++;
            if (stb_n[6:2] != 5'h1F) apin = addr_pins[23:20];
            if (low_chip_selects_n != 4'hF) ncs++;
            if (done) gap++;
            seen |= {data_oe, ~stb_n};
            if (rsp_valid === 1'b1) begin
                done = 1'b1;
                rdat = rsp_rdata;
                rerr = rsp_error;
            end
            @(posedge clk);
        end
    endtask : acc

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end

    initial begin
        sys_rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        cs_cfg = '0;
        high_cs_enable = 4'h0;
        byte_select_mode = 1'b0;
        remap_set = 1'b0;
        boot_mode_select_pin = 1'b1;
        narrow = 1'b0;
        stall = 3'h0;
        cs_cfg[1] = mk(6'h01, 1'b1, 1'b0, 3'h0, 3'h0);
        cs_cfg[2] = mk(6'h02, 1'b0, 1'b1, 3'h2, 3'h2);
        cs_cfg[3] = mk(6'h03, 1'b1, 1'b1, 3'h0, 3'h0);
        cs_cfg[4] = mk(6'h05, 1'b1, 1'b0, 3'h0, 3'h0);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        `EBU_CHK(addr_pins, 24'h00_0000)
        `EBU_CHK({stb_n, low_chip_selects_n, req_ready}, 12'hFFF)
        `EBU_CHK({boot_width16, remap_done}, 2'h2)
        acc(1'b1, 26'h010_0010, 16'h1234, 2'h3);
        `EBU_CHK({seen, nstb[3:0], gap[3:0]}, 16'hE010)
        acc(1'b0, 26'h010_0010, 16'h0000, 2'h3);
        `EBU_CHK({rdat, rerr, seen}, 25'h024_6810)
        `EBU_CHK({nstb[3:0], ncs[3:0], gap[3:0]}, 12'h120)
        acc(1'b0, 26'h030_0010, 16'h0000, 2'h3);
        `EBU_CHK({rdat, nstb[3:0], ncs[3:0]}, 24'h12_3413)
        stall <= 3'h3;
        acc(1'b0, 26'h010_0010, 16'h0000, 2'h3);
        `EBU_CHK({rdat, nstb[3:0]}, 20'h1_2344)
        stall <= 3'h0;
        acc(1'b1, 26'h010_0012, 16'h5566, 2'h1);
        `EBU_CHK(seen, 8'hC0)
        acc(1'b1, 26'h010_0012, 16'h7788, 2'h2);
        `EBU_CHK(seen, 8'hA0)
        acc(1'b0, 26'h010_0012, 16'h0000, 2'h3);
        `EBU_CHK(rdat, 16'h7766)
        byte_select_mode <= 1'b1;
        acc(1'b1, 26'h010_0012, 16'h99AA, 2'h2);
        `EBU_CHK(seen, 8'h8A)
        acc(1'b0, 26'h010_0012, 16'h0000, 2'h3);
        `EBU_CHK({rdat, seen}, 24'h99_6607)
        byte_select_mode <= 1'b0;
        narrow <= 1'b1;
        acc(1'b1, 26'h020_0020, 16'hABCD, 2'h3);
        `EBU_CHK({nstb[3:0], gap[3:0]}, 8'h62)
        acc(1'b0, 26'h020_0020, 16'h0000, 2'h3);
        `EBU_CHK(rdat, 16'hABCD)
        narrow <= 1'b0;
        acc(1'b0, 26'h3F0_0000, 16'h0000, 2'h3);
        `EBU_CHK({rerr, seen, nstb[3:0], ncs[3:0]}, 17'h1_0000)
        acc(1'b1, 26'h050_0004, 16'h0001, 2'h3);
        `EBU_CHK({rerr, apin}, 5'h05)
        high_cs_enable <= 4'h1;
        acc(1'b1, 26'h050_0004, 16'h0001, 2'h3);
        `EBU_CHK({rerr, apin}, 5'h0D)
        `EBU_CHK(addr_pins[23], 1'b0)
        acc(1'b1, 26'h000_0040, 16'hBEEF, 2'h3);
        `EBU_CHK({rerr, seen, ncs[3:0]}, 13'h0E03)
        @(posedge clk);
        remap_set <= 1'b1;
        @(posedge clk);
        remap_set <= 1'b0;
        acc(1'b0, 26'h000_0040, 16'h0000, 2'h3);
        `EBU_CHK({rerr, remap_done}, 2'h3)
        sys_rst <= 1'b1;
        boot_mode_select_pin <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        narrow <= 1'b1;
        @(posedge clk);
        #1;
        `EBU_CHK({boot_width16, remap_done, req_ready}, 3'h1)
        acc(1'b1, 26'h000_0050, 16'h1357, 2'h3);
        `EBU_CHK({rerr, nstb[3:0]}, 5'h02)
        acc(1'b0, 26'h000_0050, 16'h0000, 2'h3);
        `EBU_CHK(rdat, 16'h1357)
        test_done();
    end
endmodule : ebu_top_tb

`default_nettype wire
